// [core/adc_status_flag_logic.sv]
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module adc_status_flag_logic
    import adc_flag_pkg::*;
#(
    parameter int N_CH  = NUM_CHAN,
    parameter int RES_W = DATA_W
) (
    input  wire logic              CLK_IN,
    input  wire logic              RST_B_IN,
    input  wire logic              PSEL_IN,
    input  wire logic              PENABLE_IN,
    input  wire logic              PWRITE_IN,
    input  wire logic [ADDR_W-1:0] PADDR_IN,
    input  wire logic [31:0]       PWDATA_IN,
    input  wire logic [RES_W-1:0]  CONV_DATA_IN,
    output logic      [31:0]       PRDATA_OUT,
    output logic                   PREADY_OUT,
    output logic                   PSLVERR_OUT,
    output logic      [N_CH-1:0]   CHAN_SEL_OUT,
    output logic                   CONV_START_OUT,
    output logic                   POWER_DOWN_OUT
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (N_CH != NUM_CHAN || RES_W != DATA_W) begin : g_bad_param
        $error("Channel count and result width must match the package");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {IDLE, CONVERT, SLEEPING} conv_state_e;

    typedef struct packed {
        conv_state_e                   state;
        logic [4:0]                    cnt;
        logic [CHAN_W-1:0]             chan;
        logic [N_CH-1:0]               ch_en;
        logic                          sleep_mode;
        logic                          start_pend;
        logic [N_CH-1:0]               eoc;
        logic [N_CH-1:0]               ovr;
        logic                          data_ready_flag;
        logic                          govr;
        logic [N_CH-1:0][RES_W-1:0]    res;
        logic [RES_W-1:0]              last;
        logic [CHAN_W-1:0]             last_chan;
        logic [31:0]                   rdata;
        logic                          ready;
        logic                          slverr;
        logic [N_CH-1:0]               chan_sel;
        logic                          conv_start;
        logic                          power_down;
    } state_s;

    state_s cur_ff;
    state_s nxt_cur;
    conv_res_s done;
    apb_req_s  req;

    logic               setup;
    logic               rd_stat;
    logic               rd_last;
    logic [N_CH-1:0]    rd_chan;
    logic [N_CH-1:0]    eoc_hit;
    logic [CHAN_W-1:0]  next_ch;
    logic               found;
    logic [31:0]        rd_val;
    logic               mapped;

    assign req = '{psel: PSEL_IN, penable: PENABLE_IN, pwrite: PWRITE_IN,
                   paddr: PADDR_IN, pwdata: PWDATA_IN};

    // ------------------------------------------------------------------
    // Access decode; reads act in the setup cycle so effects are single
    // ------------------------------------------------------------------
    always_comb begin
        setup   = req.psel && !req.penable;
        rd_stat = setup && !req.pwrite && req.paddr == STAT_OFS;
        rd_last = setup && !req.pwrite && req.paddr == LAST_OFS;
        mapped  = 1'b1;
        rd_val  = RDATA_RST;
        rd_chan = '0;
        for (int i = 0; i < N_CH; i++) begin
            if (req.paddr == CHRES0_OFS + ADDR_W'(4 * i)) begin
                rd_chan[i] = setup && !req.pwrite;
                rd_val     = 32'(cur_ff.res[i]);
            end
        end
        unique case (req.paddr)
            CTRL_OFS, CHEN_OFS, CHDIS_OFS: rd_val = RDATA_RST;
            MODE_OFS:  rd_val = 32'(cur_ff.sleep_mode) << MODE_SLEEP_BIT;
            CHSR_OFS:  rd_val = 32'(cur_ff.ch_en);
            STAT_OFS: begin
                rd_val = 32'(cur_ff.eoc)
                       | (32'(cur_ff.ovr) << STAT_OVR_LSB);
                rd_val[STAT_DATA_READY_FLAG_BIT]  = cur_ff.data_ready_flag;
                rd_val[STAT_GOVR_BIT]  = cur_ff.govr;
                rd_val[STAT_SLEEP_BIT] = cur_ff.power_down;
                rd_val[STAT_BUSY_BIT]  = cur_ff.state == CONVERT;
            end
            LAST_OFS: rd_val = 32'(cur_ff.last)
                             | (32'(cur_ff.last_chan) << LAST_CHAN_LSB);
            default:  mapped = |rd_chan;
        endcase
    end

    // ------------------------------------------------------------------
    // Conversion result of this cycle
    // ------------------------------------------------------------------
    always_comb begin
        done.valid = cur_ff.state == CONVERT && cur_ff.cnt == 5'd0;
        done.chan  = cur_ff.chan;
        done.data  = CONV_DATA_IN;
        eoc_hit    = '0;
        if (done.valid) begin
            eoc_hit[done.chan] = 1'b1;
        end
    end

    // Next enabled channel after the current one, wrapping
    always_comb begin
        next_ch = cur_ff.chan;
        found   = 1'b0;
        for (int k = 1; k <= N_CH; k++) begin
            if (!found && cur_ff.ch_en[CHAN_W'((int'(cur_ff.chan) + k)
                                               % N_CH)]) begin
                next_ch = CHAN_W'((int'(cur_ff.chan) + k) % N_CH);
                found   = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_cur            = cur_ff;
        nxt_cur.conv_start = 1'b0;
        nxt_cur.ready      = 1'b0;
        nxt_cur.slverr     = 1'b0;

        // APB answer one cycle after setup
        if (setup) begin
            nxt_cur.ready  = 1'b1;
            nxt_cur.slverr = !mapped;
            nxt_cur.rdata  = req.pwrite ? RDATA_RST : rd_val;
            if (req.pwrite) begin
                unique case (req.paddr)
                    CTRL_OFS: if (req.pwdata[CTRL_START_BIT]) begin
                        nxt_cur.start_pend = 1'b1;
                    end
                    MODE_OFS:  nxt_cur.sleep_mode = req.pwdata[MODE_SLEEP_BIT];
                    CHEN_OFS:  nxt_cur.ch_en = cur_ff.ch_en | req.pwdata[N_CH-1:0];
                    CHDIS_OFS: nxt_cur.ch_en = cur_ff.ch_en & ~req.pwdata[N_CH-1:0];
                    default: ;
                endcase
            end
        end

        // Clears first, so a coinciding set wins, except ovr, which a coinciding status read clears
        if (rd_last) begin
            nxt_cur.data_ready_flag = 1'b0;
            nxt_cur.eoc  = '0;
        end
        nxt_cur.eoc = nxt_cur.eoc & ~rd_chan;
        if (rd_stat) begin
            nxt_cur.ovr  = '0;
            nxt_cur.govr = 1'b0;
        end

        // Enable is sampled at the start, so a disable now cannot stall it
        if (done.valid) begin
            nxt_cur.res[done.chan] = done.data;
            nxt_cur.last           = done.data;
            nxt_cur.last_chan      = done.chan;
            nxt_cur.data_ready_flag           = 1'b1;
            nxt_cur.eoc            = nxt_cur.eoc | eoc_hit;
            if (cur_ff.eoc[done.chan]) begin
                nxt_cur.ovr[done.chan] = !rd_stat;
            end
            if (cur_ff.data_ready_flag) begin
                nxt_cur.govr = 1'b1;
            end
        end

        // Sequencer
        unique case (cur_ff.state)
            IDLE, SLEEPING: begin
                if (cur_ff.start_pend && |cur_ff.ch_en) begin
                    nxt_cur.start_pend = 1'b0;
                    nxt_cur.state      = CONVERT;
                    nxt_cur.cnt        = 5'(CONV_CYCLES - 1);
                    nxt_cur.chan       = found ? next_ch : cur_ff.chan;
                    nxt_cur.conv_start = 1'b1;
                    nxt_cur.power_down = 1'b0;
                    nxt_cur.chan_sel   = '0;
                    nxt_cur.chan_sel[found ? next_ch : cur_ff.chan] = 1'b1;
                end
            end
            CONVERT: begin
                if (cur_ff.cnt != 5'd0) begin
                    nxt_cur.cnt = cur_ff.cnt - 5'd1;
                end else begin
                    // Sleep only powers down at a conversion end, even if
                    // it was selected while idle
                    nxt_cur.state      = cur_ff.sleep_mode ? SLEEPING : IDLE;
                    nxt_cur.power_down = cur_ff.sleep_mode;
                    nxt_cur.chan_sel   = '0;
                end
            end
            default: nxt_cur.state = IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            cur_ff       <= '0;
            cur_ff.state <= IDLE;
            cur_ff.chan  <= CHAN_W'(N_CH - 1);
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign PRDATA_OUT     = cur_ff.rdata;
    assign PREADY_OUT     = cur_ff.ready;
    assign PSLVERR_OUT    = cur_ff.slverr;
    assign CHAN_SEL_OUT   = cur_ff.chan_sel;
    assign CONV_START_OUT = cur_ff.conv_start;
    assign POWER_DOWN_OUT = cur_ff.power_down;

endmodule : adc_status_flag_logic

`default_nettype wire

// [core/adc_flag_pkg.sv]
package adc_flag_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_CHAN  = 8;
    localparam int DATA_W    = 10;
    localparam int ADDR_W    = 12;
    localparam int CHAN_W    = 3;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CTRL_OFS   = 12'h000;
    localparam logic [ADDR_W-1:0] MODE_OFS   = 12'h004;
    localparam logic [ADDR_W-1:0] CHEN_OFS   = 12'h010;
    localparam logic [ADDR_W-1:0] CHDIS_OFS  = 12'h014;
    localparam logic [ADDR_W-1:0] CHSR_OFS   = 12'h018;
    localparam logic [ADDR_W-1:0] STAT_OFS   = 12'h01C;
    localparam logic [ADDR_W-1:0] LAST_OFS   = 12'h020;
    localparam logic [ADDR_W-1:0] CHRES0_OFS = 12'h030;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_START_BIT = 1;
    localparam int MODE_SLEEP_BIT = 5;
    localparam int STAT_OVR_LSB   = 8;
    localparam int STAT_DATA_READY_FLAG_BIT  = 16;
    localparam int STAT_GOVR_BIT  = 17;
    localparam int STAT_SLEEP_BIT = 18;
    localparam int STAT_BUSY_BIT  = 19;
    localparam int LAST_CHAN_LSB  = 16;

    // ------------------------------------------------------------------
    // Timing and reset values
    // ------------------------------------------------------------------
    localparam int CONV_CYCLES = 20;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                  psel;
        logic                  penable;
        logic                  pwrite;
        logic [ADDR_W-1:0]     paddr;
        logic [31:0]           pwdata;
    } apb_req_s;

    typedef struct packed {
        logic                  valid;
        logic [CHAN_W-1:0]     chan;
        logic [DATA_W-1:0]     data;
    } conv_res_s;

endpackage : adc_flag_pkg

// [dv/adc_flag_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_flag_checker
    import adc_flag_pkg::*;
#(
    parameter int N_CH  = NUM_CHAN,
    parameter int RES_W = DATA_W
) (
    input wire logic              CLK_IN,
    input wire logic              RST_B_IN,
    input wire logic              PSEL_IN,
    input wire logic              PENABLE_IN,
    input wire logic              PWRITE_IN,
    input wire logic [ADDR_W-1:0] PADDR_IN,
    input wire logic [31:0]       PWDATA_IN,
    input wire logic [RES_W-1:0]  CONV_DATA_IN,
    input wire logic [31:0]       PRDATA_OUT,
    input wire logic              PREADY_OUT,
    input wire logic              PSLVERR_OUT,
    input wire logic [N_CH-1:0]   CHAN_SEL_OUT,
    input wire logic              CONV_START_OUT,
    input wire logic              POWER_DOWN_OUT
);
    // -------------------
    // Port relations
    // -------------------
    default clocking dc @(posedge CLK_IN);
    endclocking
    default disable iff (!RST_B_IN);
    a_ready_setup: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
        else $error("no ready after setup");
    a_ready_access: assert property (PREADY_OUT |-> PSEL_IN && PENABLE_IN)
        else $error("ready outside access");
    a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready held too long");
    a_error_data: assert property (
        PSLVERR_OUT |-> PREADY_OUT && PRDATA_OUT == 32'h0)
        else $error("bad error response");
    a_start_onehot: assert property (CONV_START_OUT |-> $onehot(CHAN_SEL_OUT))
        else $error("channel select not one-hot");
    a_start_pulse: assert property (CONV_START_OUT |=> !CONV_START_OUT)
        else $error("start not a pulse");
    // Channel must not move while the converter samples it
    a_chan_held: assert property (
        CONV_START_OUT |=> $stable(CHAN_SEL_OUT)[*8])
        else $error("channel changed in conversion");
    a_reset_quiet: assert property (!$past(RST_B_IN) |-> !PREADY_OUT &&
        !CONV_START_OUT && !POWER_DOWN_OUT && CHAN_SEL_OUT == '0)
        else $error("outputs active after reset");
    a_sleep_end: assert property (
        $rose(POWER_DOWN_OUT) |-> $past(CHAN_SEL_OUT) != '0)
        else $error("power down without conversion");
endmodule : adc_flag_checker

bind adc_status_flag_logic adc_flag_checker #(
    .N_CH(N_CH), .RES_W(RES_W)
) adc_flag_checker_inst (
    .CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PWDATA_IN(PWDATA_IN), .CONV_DATA_IN(CONV_DATA_IN),
    .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .CHAN_SEL_OUT(CHAN_SEL_OUT),
    .CONV_START_OUT(CONV_START_OUT), .POWER_DOWN_OUT(POWER_DOWN_OUT)
);
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench
    import adc_flag_pkg::*;
;
    // -------------------
    // Bench state
    // -------------------
    typedef struct packed {
        logic              w;
        logic [ADDR_W-1:0] a;
        logic [31:0]       d;
        logic [31:0]       q;
        logic              e;
    } row_s;
    localparam row_s ROWS [10] = '{
        '{1'b1, CHEN_OFS, 32'h7, 32'h0, 1'b0},
        '{1'b0, CHSR_OFS, 32'h0, 32'h7, 1'b0},
        '{1'b1, CHDIS_OFS, 32'h4, 32'h0, 1'b0},
        '{1'b0, CHSR_OFS, 32'h0, 32'h3, 1'b0},
        '{1'b1, STAT_OFS, 32'hFFFF_FFFF, 32'h0, 1'b0},
        '{1'b0, STAT_OFS, 32'h0, 32'h0, 1'b0},
        '{1'b1, MODE_OFS, 32'h20, 32'h0, 1'b0},
        '{1'b0, MODE_OFS, 32'h0, 32'h20, 1'b0},
        '{1'b0, 12'hFFC, 32'h0, 32'h0, 1'b1},
        '{1'b1, 12'hFFC, 32'h5, 32'h0, 1'b1}};
    logic                clk, rst_b, psel, pen, pwr, rerr;
    logic [ADDR_W-1:0]   paddr;
    logic [31:0]         pwdata, prdata, rd;
    logic [DATA_W-1:0]   cdata;
    logic                pready, perr, cstart, pdown;
    logic [NUM_CHAN-1:0] csel;
    int                  err_count, total_checks, n, k;

    adc_status_flag_logic adc_status_flag_logic_inst (
        .CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .CONV_DATA_IN(cdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(perr), .CHAN_SEL_OUT(csel), .CONV_START_OUT(cstart),
        .POWER_DOWN_OUT(pdown));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic close_out;
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    task automatic do_reset;
        rst_b <= 1'b0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
    endtask : do_reset

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd   = prdata;
        rerr = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
        if (pready !== 1'b1) begin
            err_count++;
            close_out();
        end
    endtask : apb

    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] q);
        apb(1'b0, a, 32'h0);
        check(rd, q);
    endtask : rchk

    task automatic convert(input logic [DATA_W-1:0] d, input int w,
                           input int c);
        cdata <= d;
        apb(1'b1, CTRL_OFS, 32'h2);
        n = 0;
        while (cstart !== 1'b1 && n < 10) begin
            @(posedge clk);
            n++;
        end
        check({31'h0, cstart}, 32'h1);
        if (cstart !== 1'b1)
            close_out();
        check({24'h0, csel}, 32'h1 << c);
        repeat (w) @(posedge clk);
    endtask : convert

    // -------------------
    // Main sequence
    // -------------------
    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        paddr = '0;
        pwdata = '0;
        cdata = '0;
        err_count = 0;
        total_checks = 0;
        do_reset();
        for (int j = 0; j < 10; j++) begin
            apb(ROWS[j].w, ROWS[j].a, ROWS[j].d);
            if (!ROWS[j].w)
                check(rd, ROWS[j].q);
            check({31'h0, rerr}, {31'h0, ROWS[j].e});
        end
        // Read slides across the conversion end; results hold at any offset
        for (k = 15; k < 22; k++) begin
            do_reset();
            rchk(STAT_OFS, 32'h0);
            apb(1'b1, CHEN_OFS, 32'h7); // Channels 0 to 2 enabled, 3 to 7 left off
            convert(10'h111, 22, 0);
            convert(10'h222, 22, 1);
            convert(10'h333, 22, 2);
            rchk(STAT_OFS, 32'h0003_0007);
            convert(10'h0AB, k, 0);
            rchk(CHRES0_OFS + 12'h4, 32'h222);
            repeat (22) @(posedge clk);
            rchk(STAT_OFS, 32'h0003_0105);
            rchk(CHRES0_OFS, 32'h0AB);
            rchk(STAT_OFS, 32'h0001_0004);
            rchk(LAST_OFS, 32'h0AB);
            rchk(STAT_OFS, 32'h0);
            do_reset();
            apb(1'b1, CHEN_OFS, 32'h1);
            convert(10'h055, 22, 0);
            convert(10'h056, 22, 0);
            rchk(LAST_OFS, 32'h056);
            convert(10'h057, k, 0);
            apb(1'b0, STAT_OFS, 32'h0);
            repeat (22) @(posedge clk);
            rchk(STAT_OFS, 32'h0001_0001);
        end
        do_reset();
        apb(1'b1, CHEN_OFS, 32'h1);
        apb(1'b1, MODE_OFS, 32'h20); // Sleep set before start
        repeat (30) @(posedge clk);
        check({31'h0, pdown}, 32'h0);
        convert(10'h3FF, 10, 0);
        check({31'h0, pdown}, 32'h0);
        repeat (14) @(posedge clk);
        check({31'h0, pdown}, 32'h1);
        rchk(STAT_OFS, 32'h0005_0001);
        close_out();
    end
endmodule : testbench
`default_nettype wire
